// [dram_host_ctrl.sv]
// Overview of operation
// - with early writes only, data in and out may share one board wire.
// - a memory is selected by the row strobe alone or by both strobes.
// - all 128 rows (low 7 address bits) are refreshed at least every 2 ms.
// - a row-strobe-only cycle refreshes its row and may cover all rows.
`timescale 1ns/1ps
module dram_host_ctrl (
  input  wire logic                               clk,           // 250 MHz
  input  wire logic                               sys_rst,       // async, high
  input  wire logic                               ce,            // freeze when low
  input  wire logic                               reqValid,      // access request
  input  wire logic                               reqWrite,      // 1 = write
  input  wire logic                               reqRmw,        // read then write
  input  wire logic [dram_host_pkg::ADDR_BITS-1:0] reqAddr,      // col:row
  input  wire logic                               reqData,       // write bit
  output logic                                    reqReady,      // may accept
  output logic                                    rspValid,      // read bit pulse
  output logic                                    rspData,       // read bit
  output logic                                    rowStrobe_n,   // row strobe
  output logic                                    colStrobe_n,   // column strobe
  output logic                                    writeStrobe_n, // write strobe
  output logic [dram_host_pkg::ROW_BITS-1:0]      memAddr,       // muxed address
  output logic                                    memDin,        // data to memory
  input  wire logic                               memDout        // data from memory
);

  dram_host_pkg::state_t state_reg, stateNext;

  logic [dram_host_pkg::CNT_BITS-1:0]       cnt_reg;
  logic [dram_host_pkg::REF_TIMER_BITS-1:0] refTimer_reg;
  logic [dram_host_pkg::ROW_BITS-1:0]       refRow_reg;
  logic [dram_host_pkg::ADDR_BITS-1:0]      curAddr_reg;
  logic                                     curWrite_reg;
  logic                                     curRmw_reg;
  logic                                     curData_reg;
  logic                                     refPending_reg;
  logic                                     pend_reg;

  function automatic logic [dram_host_pkg::CNT_BITS-1:0] durOf(
    input dram_host_pkg::state_t s);
    int d;
    case (s)
      dram_host_pkg::ST_ROW:  d = dram_host_pkg::ROW_TO_COL_CYC;
      dram_host_pkg::ST_COL:  d = dram_host_pkg::COL_ACCESS_CYC;
      dram_host_pkg::ST_RMWW: d = dram_host_pkg::WRITE_PULSE_CYC;
      dram_host_pkg::ST_CEND: d = dram_host_pkg::COL_PRECH_CYC;
      dram_host_pkg::ST_PRE:  d = dram_host_pkg::ROW_PRECH_CYC;
      dram_host_pkg::ST_REF:  d = dram_host_pkg::ROW_ACTIVE_CYC;
      default:                d = 1;
    endcase
    return dram_host_pkg::CNT_BITS'(d - 1);
  endfunction : durOf

  wire cntZero  = (cnt_reg == '0);
  wire accept   = reqValid & reqReady;
  wire readOp   = ~curWrite_reg | curRmw_reg;
  wire pageHit  = (reqAddr[dram_host_pkg::ROW_BITS-1:0] ==
                   curAddr_reg[dram_host_pkg::ROW_BITS-1:0]);
  // a request being taken drives the pins at the very edge that stores
  // it, so its own fields must be used in that cycle, not the old ones
  wire [dram_host_pkg::ADDR_BITS-1:0] opAddr =
    accept ? reqAddr : curAddr_reg;
  wire opWrite  = accept ? (reqWrite | reqRmw) : curWrite_reg;
  wire opRmw    = accept ? reqRmw : curRmw_reg;
  wire opData   = accept ? reqData : curData_reg;
  wire [dram_host_pkg::ROW_BITS-1:0] curRow =
    opAddr[dram_host_pkg::ROW_BITS-1:0];
  wire [dram_host_pkg::COL_BITS-1:0] curCol =
    opAddr[dram_host_pkg::ADDR_BITS-1:dram_host_pkg::ROW_BITS];
  wire refTick  = (refTimer_reg == dram_host_pkg::REF_TIMER_BITS'(
                   dram_host_pkg::REFRESH_INTERVAL_CYC - 1));
  wire refStart = (state_reg != dram_host_pkg::ST_REF) &&
                  (stateNext == dram_host_pkg::ST_REF);
  wire refDone  = (state_reg == dram_host_pkg::ST_REF) && cntZero;
  // a taken miss must survive the whole precharge, or it would be lost
  wire preDone  = (state_reg == dram_host_pkg::ST_PRE) && cntZero;
  wire pendNext = accept ? ((state_reg == dram_host_pkg::ST_PAGE) & ~pageHit)
                         : (pend_reg & ~preDone);
  // a tick in the same cycle as a refresh start stays pending
  wire refPendingNext = refTick | (refPending_reg & ~refStart);

  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      dram_host_pkg::ST_IDLE: begin
        if (accept) begin
          stateNext = dram_host_pkg::ST_ROW;
        end else if (refPending_reg) begin
          stateNext = dram_host_pkg::ST_REF;
        end
      end
      dram_host_pkg::ST_ROW: begin
        if (cntZero) stateNext = dram_host_pkg::ST_COL;
      end
      dram_host_pkg::ST_COL: begin
        if (cntZero) begin
          stateNext = curRmw_reg ? dram_host_pkg::ST_RMWW
                                 : dram_host_pkg::ST_CEND;
        end
      end
      dram_host_pkg::ST_RMWW: begin
        if (cntZero) stateNext = dram_host_pkg::ST_CEND;
      end
      dram_host_pkg::ST_CEND: begin
        if (cntZero) stateNext = dram_host_pkg::ST_PAGE;
      end
      dram_host_pkg::ST_PAGE: begin
        // row stays open: a hit reuses it with a column cycle only
        if (accept) begin
          stateNext = pageHit ? dram_host_pkg::ST_COL
                              : dram_host_pkg::ST_PRE;
        end else if (refPending_reg) begin
          stateNext = dram_host_pkg::ST_PRE;
        end
      end
      dram_host_pkg::ST_PRE: begin
        if (cntZero) begin
          stateNext = pend_reg ? dram_host_pkg::ST_ROW
                               : dram_host_pkg::ST_IDLE;
        end
      end
      dram_host_pkg::ST_REF: begin
        if (cntZero) stateNext = dram_host_pkg::ST_PRE;
      end
      default: stateNext = dram_host_pkg::ST_IDLE;
    endcase
  end

  wire readyNext = ((stateNext == dram_host_pkg::ST_IDLE) ||
                    (stateNext == dram_host_pkg::ST_PAGE)) &&
                   ~refPendingNext && ~pendNext;
  // row strobe alone selects in refresh; column needs an open row
  wire rowNext   = ~((stateNext == dram_host_pkg::ST_IDLE) ||
                     (stateNext == dram_host_pkg::ST_PRE));
  wire colNext   = (stateNext == dram_host_pkg::ST_COL) ||
                   (stateNext == dram_host_pkg::ST_RMWW);
  // plain writes drop the write strobe at the same edge as the column strobe, so
  // the memory output never turns on and a shared data wire is safe
  wire wrNext    = ((stateNext == dram_host_pkg::ST_COL) &&
                    opWrite && ~opRmw) ||
                   (stateNext == dram_host_pkg::ST_RMWW);
  wire [dram_host_pkg::ROW_BITS-1:0] addrNext =
    (stateNext == dram_host_pkg::ST_REF) ? refRow_reg :
    (stateNext == dram_host_pkg::ST_ROW) ? curRow :
    colNext ? curCol : memAddr;
  // sample on the last access cycle, while the column strobe still
  // holds the output; nothing is kept past the strobe
  wire rspNext = (state_reg == dram_host_pkg::ST_COL) && cntZero &&
                 readOp;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= dram_host_pkg::ST_IDLE;
      cnt_reg   <= '0;
      pend_reg  <= 1'b0;
    end else if (ce) begin
      state_reg <= stateNext;
      cnt_reg   <= (stateNext != state_reg) ? durOf(stateNext) :
                   cntZero ? cnt_reg : cnt_reg - 1'b1;
      pend_reg  <= pendNext;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      refTimer_reg   <= '0;
      refPending_reg <= 1'b0;
      refRow_reg     <= dram_host_pkg::REF_ROW_RESET;
    end else if (ce) begin
      refTimer_reg   <= refTick ? '0 : refTimer_reg + 1'b1;
      refPending_reg <= refPendingNext;
      if (refDone) refRow_reg <= refRow_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      curAddr_reg  <= '0;
      curWrite_reg <= 1'b0;
      curRmw_reg   <= 1'b0;
      curData_reg  <= 1'b0;
    end else if (ce && accept) begin
      curAddr_reg  <= reqAddr;
      curWrite_reg <= reqWrite | reqRmw;
      curRmw_reg   <= reqRmw;
      curData_reg  <= reqData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspData       <= 1'b0;
      rowStrobe_n   <= 1'b1;
      colStrobe_n   <= 1'b1;
      writeStrobe_n <= 1'b1;
      memAddr       <= '0;
      memDin        <= 1'b0;
    end else if (ce) begin
      reqReady      <= readyNext;
      rspValid      <= rspNext;
      if (rspNext) rspData <= memDout;
      rowStrobe_n   <= ~rowNext;
      colStrobe_n   <= ~colNext;
      writeStrobe_n <= ~wrNext;
      memAddr       <= addrNext;
      memDin        <= opData;
    end
  end

  // cycles since the last refresh started, for checking only
  logic [12:0] gapCnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gapCnt <= '0;
    end else if (ce) begin
      gapCnt <= refStart ? '0 : (&gapCnt ? gapCnt : gapCnt + 1'b1);
    end
  end

  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (sys_rst);

  sequence refEntry;
    (state_reg == dram_host_pkg::ST_REF) && !rowStrobe_n;
  endsequence
  sequence refLeave;
    (state_reg == dram_host_pkg::ST_PRE) && rowStrobe_n;
  endsequence

  chk_refresh_gap: assert property (
    gapCnt <= 13'(dram_host_pkg::REFRESH_INTERVAL_CYC +
                  dram_host_pkg::GAP_SLACK_CYC))
    else $error("refresh gap too long");
  chk_ras_only_row: assert property (
    $rose(state_reg == dram_host_pkg::ST_REF) |=>
      colStrobe_n && writeStrobe_n && (memAddr == refRow_reg))
    else $error("row-only refresh cycle malformed");
  chk_row_advance: assert property (
    refEntry ##1 refLeave |-> refRow_reg == $past(refRow_reg, 2) + 1'b1)
    else $error("refresh row did not advance");
  chk_early_write: assert property (
    $fell(colStrobe_n) && curWrite_reg && !curRmw_reg |-> !writeStrobe_n)
    else $error("write strobe late on plain write");
  chk_col_select: assert property (
    !colStrobe_n |-> !rowStrobe_n)
    else $error("column strobe without row strobe");
  chk_read_sample: assert property (
    rspValid |-> $past(!colStrobe_n) && (colStrobe_n == !curRmw_reg))
    else $error("read sampled outside column strobe");

endmodule : dram_host_ctrl

// [dram_host_pkg.sv]
package dram_host_pkg;

  localparam int CLK_PERIOD_NS  = 4;
  localparam int ROW_BITS       = 7;
  localparam int COL_BITS       = 7;
  localparam int ADDR_BITS      = ROW_BITS + COL_BITS;
  localparam int ROW_COUNT      = 128;

  // whole-array refresh period, spread evenly over all rows
  localparam int REFRESH_PERIOD_MS    = 2;
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_MS * 1000000) / ROW_COUNT / CLK_PERIOD_NS;
  localparam int REF_TIMER_BITS       = 12;
  localparam int GAP_SLACK_CYC        = 128;

  // strobe timing, plain defaults
  localparam int T_ROW_TO_COL_NS = 50;
  localparam int T_COL_ACCESS_NS = 100;
  localparam int T_WRITE_PULSE_NS = 45;
  localparam int T_COL_PRECH_NS  = 40;
  localparam int T_ROW_PRECH_NS  = 100;
  localparam int T_ROW_ACTIVE_NS = 150;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int ROW_TO_COL_CYC  = ns_to_cyc(T_ROW_TO_COL_NS);
  localparam int COL_ACCESS_CYC  = ns_to_cyc(T_COL_ACCESS_NS);
  localparam int WRITE_PULSE_CYC = ns_to_cyc(T_WRITE_PULSE_NS);
  localparam int COL_PRECH_CYC   = ns_to_cyc(T_COL_PRECH_NS);
  localparam int ROW_PRECH_CYC   = ns_to_cyc(T_ROW_PRECH_NS);
  localparam int ROW_ACTIVE_CYC  = ns_to_cyc(T_ROW_ACTIVE_NS);
  localparam int CNT_BITS        = 6;

  localparam logic [ROW_BITS-1:0] REF_ROW_RESET = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ROW   = 3'h1,
    ST_COL   = 3'h3,
    ST_CEND  = 3'h2,
    ST_PAGE  = 3'h6,
    ST_PRE   = 3'h7,
    ST_REF   = 3'h5,
    ST_RMWW  = 3'h4
  } state_t;

endpackage : dram_host_pkg

// [dram_cell_model.sv]
`timescale 1ns/1ps
module dram_cell_model #(
  parameter int ACC_NS = 20
) (
  input  wire logic       rowStrobe_n,   // row strobe
  input  wire logic       colStrobe_n,   // column strobe
  input  wire logic       writeStrobe_n, // write strobe
  input  wire logic [6:0] memAddr,       // muxed address
  input  wire logic       memDin,        // data in
  output logic            memDout,       // data out
  output int              refCount,      // row-only cycles seen
  output logic [6:0]      lastRefRow     // row of the last one
);
  logic       cells [0:16383];
  logic [6:0] rowLat;
  logic [6:0] colLat;
  logic       colSeen;
  logic       lastOut;
  initial begin
    for (int i = 0; i < 16384; i++) cells[i] = 1'b0;
    refCount = 0;
    lastRefRow = 7'h00;
    rowLat = 7'h00;
    colLat = 7'h00;
    lastOut = 1'b0;
    memDout = 1'b1;
    // set so the reset-time rise of the row strobe is not counted
    colSeen = 1'b1;
  end
  // address is sampled just after the strobe edge, since both move together
  always @(negedge rowStrobe_n) begin
    #0.5;
    rowLat = memAddr;
    colSeen = 1'b0;
  end
  always @(posedge rowStrobe_n) if (!colSeen) begin
    refCount++;
    lastRefRow = rowLat;
  end
  always @(negedge colStrobe_n) begin
    memDout = ~lastOut;
    #0.5;
    colLat = memAddr;
    colSeen = 1'b1;
    if (!writeStrobe_n) cells[{colLat, rowLat}] = memDin;
    #(ACC_NS);
    if (!colStrobe_n) begin
      memDout = cells[{colLat, rowLat}];
      lastOut = memDout;
    end
  end
  always @(negedge writeStrobe_n) begin
    #1;
    if (!colStrobe_n && colSeen) cells[{colLat, rowLat}] = memDin;
  end
  // unlatched output: once released the line shows the opposite level
  always @(posedge colStrobe_n) memDout = ~lastOut;
endmodule : dram_cell_model

// [dram_refresh_access_interface_bench.sv]
`timescale 1ns/1ps
module dram_refresh_access_interface_bench;
  localparam int RC = dram_host_pkg::ROW_TO_COL_CYC;
  localparam int CA = dram_host_pkg::COL_ACCESS_CYC;
  localparam int RP = dram_host_pkg::ROW_PRECH_CYC;
  localparam int IV = dram_host_pkg::REFRESH_INTERVAL_CYC;
  localparam int SL = dram_host_pkg::GAP_SLACK_CYC;
  logic clk = 1'b0;
  logic sys_rst, ce, reqValid, reqWrite, reqRmw, reqData, memDout, memDin;
  logic reqReady, rspValid, rspData, rowStrobe_n, colStrobe_n, writeStrobe_n;
  logic [13:0] reqAddr;
  logic [6:0]  memAddr, lastRefRow;
  int          refCount, fails, totalChecks, n, g;
  logic        q;
  always #2 clk = ~clk;
  dram_host_ctrl uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqRmw(reqRmw),
    .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
    .memAddr(memAddr), .memDin(memDin), .memDout(memDout));
  dram_cell_model mem0 (.rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeStrobe_n(writeStrobe_n), .memAddr(memAddr), .memDin(memDin),
    .memDout(memDout), .refCount(refCount), .lastRefRow(lastRefRow));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic cmp_bit(input string what, input logic e, input logic s);
    totalChecks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, s);
    end
  endtask : cmp_bit
  task automatic cmp_num(input string what, input int e, input int s);
    totalChecks++;
    if (s != e) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, s);
    end
  endtask : cmp_num
  // latency n counts only enabled edges; ce is held low for hold cycles
  task automatic acc(input logic wr, input logic rmw, input logic [13:0] a,
                     input logic d, input int hold);
    int k;
    @(negedge clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqRmw = rmw;
    reqAddr = a;
    reqData = d;
    k = 0;
    while (reqReady !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    cmp_bit("request taken", 1'b1, reqReady);
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    k = 0;
    if (!wr) begin
      while (rspValid !== 1'b1 && k < 300) begin
        ce = (k >= hold);
        @(negedge clk);
        if (ce) n++;
        k++;
      end
      cmp_bit("read answered", 1'b1, rspValid);
    end
    ce = 1'b1;
    q = rspData;
  endtask : acc
  task automatic wait_ref(output int c);
    int c0;
    c0 = refCount;
    c = 0;
    while (refCount == c0 && c < IV + 4 * SL) begin
      @(negedge clk);
      c++;
    end
    cmp_bit("refresh seen", 1'b1, refCount != c0);
  endtask : wait_ref
  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_bit("row strobe in reset", 1'b1, rowStrobe_n);
    cmp_bit("col strobe in reset", 1'b1, colStrobe_n);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    cmp_bit("ready after reset", 1'b1, reqReady);
    $display("test reset done");
  endtask : t_reset
  task automatic t_page;
    acc(1'b1, 1'b0, {7'h03, 7'h05}, 1'b1, 0);
    acc(1'b1, 1'b0, {7'h04, 7'h05}, 1'b0, 0);
    acc(1'b0, 1'b0, {7'h03, 7'h05}, 1'b0, 0);
    cmp_num("page hit latency", CA, n);
    cmp_bit("page read bit", 1'b1, q);
    acc(1'b0, 1'b0, {7'h04, 7'h05}, 1'b0, 0);
    cmp_bit("page neighbour bit", 1'b0, q);
    $display("test page done");
  endtask : t_page
  task automatic t_miss;
    acc(1'b1, 1'b0, {7'h03, 7'h09}, 1'b1, 0);
    acc(1'b0, 1'b0, {7'h04, 7'h09}, 1'b0, 0);
    cmp_bit("row mate untouched", 1'b0, q);
    acc(1'b0, 1'b0, {7'h03, 7'h05}, 1'b0, 0);
    cmp_num("page miss latency", RP + RC + CA, n);
    cmp_bit("miss read bit", 1'b1, q);
    $display("test miss done");
  endtask : t_miss
  task automatic t_rmw;
    acc(1'b0, 1'b1, {7'h03, 7'h05}, 1'b0, 5);
    cmp_num("frozen rmw latency", CA, n);
    cmp_bit("rmw old bit", 1'b1, q);
    acc(1'b0, 1'b0, {7'h03, 7'h05}, 1'b0, 0);
    cmp_bit("rmw new bit", 1'b0, q);
    $display("test rmw done");
  endtask : t_rmw
  task automatic t_refresh;
    wait_ref(g);
    cmp_bit("first refresh row", 1'b1, lastRefRow === 7'h00);
    wait_ref(g);
    cmp_bit("second refresh row", 1'b1, lastRefRow === 7'h01);
    cmp_bit("refresh spacing", 1'b1, g >= IV - SL && g <= IV + SL);
    cmp_bit("period budget", 1'b1, IV * 128 * 4 <= 2000000);
    acc(1'b0, 1'b0, {7'h03, 7'h05}, 1'b0, 0);
    cmp_num("idle latency", RC + CA, n);
    cmp_bit("bit kept", 1'b0, q);
    $display("test refresh done");
  endtask : t_refresh
  initial begin
    ce = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqRmw = 1'b0;
    reqData = 1'b0;
    reqAddr = 14'h0000;
    fails = 0;
    totalChecks = 0;
    t_reset;
    t_page;
    t_miss;
    t_rmw;
    t_refresh;
    wrap_up;
  end
  // the whole run needs about two refresh intervals
  initial begin
    #(4 * 20000);
    fails++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule : dram_refresh_access_interface_bench
